// [src/comparison_unit.sv]
// Operation
// [RULE_01] outcome goes only to high 33, equal 34, unequal 35, low 36
// [RULE_02] neither operand is ever changed by a compare
// [RULE_03] memory address is base plus index register
// [RULE_04] binary compare: L memory chars versus L register chars, 1..16
// [RULE_05] register length marker counts as ordinary data in binary compare
// [RULE_06] binary compare is unsigned over 6L bits, no sign
// [RULE_07] register operand is its L least significant characters
// [RULE_08] less 0011, equal 0100, greater 1010, first operand versus memory
// [RULE_09] character compare: memory char against immediate, unsigned
// [RULE_10] decimal compare: signed, L memory chars, register length by marker
// [RULE_11] unlike signs end decimal compare at once, decided by signs
// [RULE_12] shorter decimal field padded with zero digits internally
// [RULE_13] decimal time 36 plus 13.5 per longer digit, 36 unlike signs
// [RULE_14] word compare: four characters, unsigned 24 bits
// [RULE_15] masked compare tests memory bits where mask is one
// [RULE_16] masked mismatch sets high and unequal; match sets equal only
// [RULE_17] indicators hold until next setting; testing never clears them
// [RULE_18] all four indicators update together at completion
module comparison_unit #(
  parameter int DEC_BASE_CYCLES = comparison_unit_pkg::DEC_BASE_CYCLES,
  parameter int DEC_DIGIT_CYCLES = comparison_unit_pkg::DEC_DIGIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [comparison_unit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [comparison_unit_pkg::CHAR_W-1:0] mem_rdata,
  output logic high_flag,
  output logic equal_flag,
  output logic unequal_flag,
  output logic low_flag,
  output logic busy,
  output logic irq
);

  localparam int AW = comparison_unit_pkg::ADDR_W;
  localparam int CW = comparison_unit_pkg::CHAR_W;
  localparam int ML = comparison_unit_pkg::MAX_LEN;
  localparam int TW = comparison_unit_pkg::TGT_W;
  localparam int FW = comparison_unit_pkg::FIELD_W;
  localparam int SB = comparison_unit_pkg::SIGN_BIT;
  localparam int DW = comparison_unit_pkg::DIGIT_W;

  comparison_unit_pkg::state_t state_q;
  comparison_unit_pkg::op_t op_q;
  logic [comparison_unit_pkg::LEN_W-1:0] len_q;
  logic [CW-1:0] imm_q;
  logic [AW-1:0] base_q;
  logic [AW-1:0] index_q;
  logic [AW-1:0] ea_q;
  logic [comparison_unit_pkg::LEN_W-1:0] idx_q;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] target_q;
  logic sign_stop_q;
  logic [31:0] ar_q [comparison_unit_pkg::AR_WORDS];
  logic [31:0] tetrad_q;
  logic [CW-1:0] membuf [ML];
  logic [5:0] ind_sel_q;
  logic [comparison_unit_pkg::EV_W-1:0] irq_status_q;
  logic [comparison_unit_pkg::EV_W-1:0] irq_mask_q;

  logic access;
  logic wr_fire;
  logic start_req;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [FW-1:0] ar_flat;
  logic [4:0] len1;
  logic [4:0] ar_len;
  logic [4:0] need;
  logic fetch_last;
  logic sign_diff;
  logic [4:0] lm;
  logic finish;
  comparison_unit_pkg::cmp_t res;
  logic [comparison_unit_pkg::EV_W-1:0] ev;

  assign access = psel & penable;
  assign wr_fire = access & pready & pwrite & rd_hit;
  assign ar_flat = {ar_q[3][23:0], ar_q[2][23:0], ar_q[1][23:0],
                    ar_q[0][23:0]};
  assign len1 = {1'b0, len_q} + 5'h01;
  // a start while busy is dropped so the running operands stay intact
  assign start_req = wr_fire && (paddr == comparison_unit_pkg::CMD_OFF) &&
                     pwdata[comparison_unit_pkg::CMD_START_BIT] &&
                     (state_q == comparison_unit_pkg::ST_IDLE);

  // selects the indicator by its jump number; reading never alters it
  function automatic logic ind_value(input logic [5:0] num,
                                     input logic h, input logic e,
                                     input logic u, input logic l);
    logic v;
    v = 1'b0;
    case (num)
      comparison_unit_pkg::IND_HIGH_NUM: v = h;
      comparison_unit_pkg::IND_EQUAL_NUM: v = e;
      comparison_unit_pkg::IND_UNEQUAL_NUM: v = u;
      comparison_unit_pkg::IND_LOW_NUM: v = l;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : ind_value

  function automatic comparison_unit_pkg::cmp_t cmp_vals(
    input logic [FW-1:0] a, input logic [FW-1:0] m);
    comparison_unit_pkg::cmp_t r;
    r = comparison_unit_pkg::CMP_EQ;
    if (a < m) begin
      r = comparison_unit_pkg::CMP_LT;
    end else if (a > m) begin
      r = comparison_unit_pkg::CMP_GT;
    end
    return r;
  endfunction : cmp_vals

  // APB read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      comparison_unit_pkg::CMD_OFF: begin
        rd_data[CW+comparison_unit_pkg::CMD_IMM_LSB-1:
                comparison_unit_pkg::CMD_IMM_LSB] = imm_q;
        rd_data[comparison_unit_pkg::CMD_LEN_LSB+3:
                comparison_unit_pkg::CMD_LEN_LSB] = len_q;
        rd_data[comparison_unit_pkg::CMD_OP_LSB+2:
                comparison_unit_pkg::CMD_OP_LSB] = op_q;
      end
      comparison_unit_pkg::BASE_OFF: rd_data[AW-1:0] = base_q;
      comparison_unit_pkg::INDEX_OFF: rd_data[AW-1:0] = index_q;
      comparison_unit_pkg::EA_OFF: rd_data[AW-1:0] = ea_q;
      comparison_unit_pkg::AR0_OFF: rd_data = ar_q[0];
      comparison_unit_pkg::AR1_OFF: rd_data = ar_q[1];
      comparison_unit_pkg::AR2_OFF: rd_data = ar_q[2];
      comparison_unit_pkg::AR3_OFF: rd_data = ar_q[3];
      comparison_unit_pkg::TETRAD_OFF: rd_data = tetrad_q;
      comparison_unit_pkg::FLAGS_OFF: begin
        rd_data[comparison_unit_pkg::FLAGS_HIGH_BIT] = high_flag;
        rd_data[comparison_unit_pkg::FLAGS_EQUAL_BIT] = equal_flag;
        rd_data[comparison_unit_pkg::FLAGS_UNEQUAL_BIT] = unequal_flag;
        rd_data[comparison_unit_pkg::FLAGS_LOW_BIT] = low_flag;
        rd_data[comparison_unit_pkg::FLAGS_BUSY_BIT] = busy;
      end
      comparison_unit_pkg::IND_TEST_OFF: begin
        rd_data[13:8] = ind_sel_q;
        // [RULE_17] non-destructive test
        rd_data[0] = ind_value(ind_sel_q, high_flag, equal_flag,
                               unequal_flag, low_flag);
      end
      comparison_unit_pkg::IRQ_STATUS_OFF: begin
        rd_data[comparison_unit_pkg::EV_W-1:0] = irq_status_q;
      end
      comparison_unit_pkg::IRQ_MASK_OFF: begin
        rd_data[comparison_unit_pkg::EV_W-1:0] = irq_mask_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait state so that every bus output leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= comparison_unit_pkg::WORD_RESET;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? comparison_unit_pkg::WORD_RESET : rd_data;
      pslverr <= !rd_hit;
    end else begin
      pready <= 1'b0;
      prdata <= comparison_unit_pkg::WORD_RESET;
      pslverr <= 1'b0;
    end
  end

  // software registers; operands are frozen while a compare runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= '0;
      index_q <= '0;
      for (int i = 0; i < comparison_unit_pkg::AR_WORDS; i++) begin
        ar_q[i] <= comparison_unit_pkg::WORD_RESET;
      end
      tetrad_q <= comparison_unit_pkg::WORD_RESET;
      ind_sel_q <= 6'h00;
      irq_mask_q <= '0;
    end else if (wr_fire) begin
      case (paddr)
        comparison_unit_pkg::BASE_OFF: base_q <= pwdata[AW-1:0];
        comparison_unit_pkg::INDEX_OFF: index_q <= pwdata[AW-1:0];
        comparison_unit_pkg::AR0_OFF, comparison_unit_pkg::AR1_OFF,
        comparison_unit_pkg::AR2_OFF, comparison_unit_pkg::AR3_OFF: begin
          if (!busy) ar_q[paddr[3:2]] <= {8'h00, pwdata[23:0]};
        end
        comparison_unit_pkg::TETRAD_OFF: begin
          if (!busy) tetrad_q <= {8'h00, pwdata[23:0]};
        end
        comparison_unit_pkg::IND_TEST_OFF: ind_sel_q <= pwdata[13:8];
        comparison_unit_pkg::IRQ_MASK_OFF: begin
          irq_mask_q <= pwdata[comparison_unit_pkg::EV_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // register field length from the position of its length marker
  always_comb begin
    ar_len = 5'h10;
    for (int i = ML - 1; i >= 0; i--) begin
      if (ar_flat[i*CW +: CW] == comparison_unit_pkg::SENTINEL) begin
        ar_len = 5'(i);
      end
    end
  end

  always_comb begin
    case (op_q)
      comparison_unit_pkg::OP_CHAR: need = 5'h01;
      comparison_unit_pkg::OP_MASKED: need = 5'h01;
      comparison_unit_pkg::OP_WORD: need = 5'h04;
      default: need = len1;
    endcase
  end

  assign fetch_last = ({1'b0, idx_q} + 5'h01) == need;
  // [RULE_11] sign check on the first (least significant) character
  assign sign_diff = (op_q == comparison_unit_pkg::OP_DECIMAL) &&
                     (idx_q == '0) &&
                     (mem_rdata[SB] != ar_flat[SB]);
  assign lm = (len1 > ar_len) ? len1 : ar_len;
  assign finish = (state_q == comparison_unit_pkg::ST_WAIT) &&
                  (timer_q >= target_q);

  // operand fetch and timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= comparison_unit_pkg::ST_IDLE;
      op_q <= comparison_unit_pkg::OP_BINARY;
      len_q <= '0;
      imm_q <= '0;
      ea_q <= '0;
      idx_q <= '0;
      timer_q <= '0;
      target_q <= '0;
      sign_stop_q <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= '0;
    end else begin
      case (state_q)
        comparison_unit_pkg::ST_IDLE: begin
          if (start_req) begin
            op_q <= comparison_unit_pkg::op_t'(pwdata[2:0]);
            len_q <= pwdata[comparison_unit_pkg::CMD_LEN_LSB+3:
                            comparison_unit_pkg::CMD_LEN_LSB];
            imm_q <= pwdata[comparison_unit_pkg::CMD_IMM_LSB+CW-1:
                            comparison_unit_pkg::CMD_IMM_LSB];
            // [RULE_03] indexed effective address
            ea_q <= base_q + index_q;
            mem_addr <= base_q + index_q;
            mem_req <= 1'b1;
            idx_q <= '0;
            timer_q <= '0;
            sign_stop_q <= 1'b0;
            state_q <= comparison_unit_pkg::ST_FETCH;
          end
        end
        comparison_unit_pkg::ST_FETCH: begin
          timer_q <= timer_q + TW'(1);
          if (mem_valid) begin
            if (fetch_last || sign_diff) begin
              mem_req <= 1'b0;
              sign_stop_q <= sign_diff;
              state_q <= comparison_unit_pkg::ST_WAIT;
              // [RULE_13] decimal duration
              if (op_q != comparison_unit_pkg::OP_DECIMAL) begin
                target_q <= '0;
              end else if (sign_diff) begin
                target_q <= TW'(DEC_BASE_CYCLES);
              end else begin
                target_q <= TW'(DEC_BASE_CYCLES) +
                            TW'(DEC_DIGIT_CYCLES) * TW'(lm);
              end
            end else begin
              idx_q <= idx_q + 4'h1;
              // characters are read from the least significant end, at falling addresses
              mem_addr <= ea_q - AW'({1'b0, idx_q} + 5'h01);
            end
          end
        end
        comparison_unit_pkg::ST_WAIT: begin
          timer_q <= timer_q + TW'(1);
          if (finish) begin
            state_q <= comparison_unit_pkg::ST_IDLE;
          end
        end
        default: state_q <= comparison_unit_pkg::ST_IDLE;
      endcase
    end
  end

  // fetched memory characters; data only, so no reset is needed
  always_ff @(posedge pclk) begin
    if (state_q == comparison_unit_pkg::ST_FETCH && mem_valid) begin
      membuf[idx_q] <= mem_rdata;
    end
  end

  // outcome; operands are only read here, never written back
  always_comb begin
    logic [FW-1:0] a_val;
    logic [FW-1:0] m_val;
    logic decided;
    logic [DW-1:0] ad;
    logic [DW-1:0] md;
    a_val = '0;
    m_val = '0;
    decided = 1'b0;
    ad = '0;
    md = '0;
    res = comparison_unit_pkg::CMP_EQ;
    case (op_q)
      comparison_unit_pkg::OP_BINARY: begin
        for (int i = 0; i < ML; i++) begin
          if (5'(i) < len1) begin
            // [RULE_05] marker taken as plain data
            // [RULE_07] low L register characters
            a_val[i*CW +: CW] = ar_flat[i*CW +: CW];
            m_val[i*CW +: CW] = membuf[i];
          end
        end
        // [RULE_04] [RULE_06] unsigned 6L-bit compare
        res = cmp_vals(a_val, m_val);
      end
      comparison_unit_pkg::OP_CHAR: begin
        a_val[CW-1:0] = imm_q;
        m_val[CW-1:0] = membuf[0];
        // [RULE_09] unsigned character compare
        res = cmp_vals(a_val, m_val);
      end
      comparison_unit_pkg::OP_WORD: begin
        a_val[4*CW-1:0] = tetrad_q[23:0];
        m_val[4*CW-1:0] = {membuf[3], membuf[2], membuf[1], membuf[0]};
        // [RULE_14] full 24-bit compare
        res = cmp_vals(a_val, m_val);
      end
      comparison_unit_pkg::OP_MASKED: begin
        // [RULE_15] [RULE_16] mismatch counts mask as higher
        res = ((membuf[0] & imm_q) == imm_q) ? comparison_unit_pkg::CMP_EQ
                                            : comparison_unit_pkg::CMP_GT;
      end
      comparison_unit_pkg::OP_DECIMAL: begin
        if (sign_stop_q) begin
          // [RULE_11] signs alone decide
          res = ar_flat[SB] ? comparison_unit_pkg::CMP_LT
                            : comparison_unit_pkg::CMP_GT;
        end else begin
          for (int i = ML - 1; i >= 0; i--) begin
            // [RULE_12] missing digits read as zero
            ad = (5'(i) < ar_len) ? ar_flat[i*CW +: DW] : '0;
            md = (5'(i) < len1) ? membuf[i][DW-1:0] : '0;
            if (!decided && ad != md) begin
              decided = 1'b1;
              res = (ad > md) ? comparison_unit_pkg::CMP_GT
                              : comparison_unit_pkg::CMP_LT;
            end
          end
          // [RULE_10] both negative reverses magnitude order
          if (ar_flat[SB] && res != comparison_unit_pkg::CMP_EQ) begin
            res = (res == comparison_unit_pkg::CMP_GT)
                  ? comparison_unit_pkg::CMP_LT
                  : comparison_unit_pkg::CMP_GT;
          end
        end
      end
      default: res = comparison_unit_pkg::CMP_EQ;
    endcase
  end

  // [RULE_01] indicators are the only result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_flag <= 1'b0;
      equal_flag <= 1'b0;
      unequal_flag <= 1'b0;
      low_flag <= 1'b0;
    end else if (finish) begin
      // [RULE_08] [RULE_18] one encoding written at once
      // [RULE_17] held between compares
      high_flag <= (res == comparison_unit_pkg::CMP_GT);
      equal_flag <= (res == comparison_unit_pkg::CMP_EQ);
      unequal_flag <= (res != comparison_unit_pkg::CMP_EQ);
      low_flag <= (res == comparison_unit_pkg::CMP_LT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= start_req || (busy && !finish);
    end
  end

  always_comb begin
    ev = '0;
    ev[comparison_unit_pkg::EV_DONE] = finish;
    ev[comparison_unit_pkg::EV_SIGN_STOP] = finish && sign_stop_q;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_fire && paddr == comparison_unit_pkg::IRQ_STATUS_OFF) begin
        irq_status_q <= (irq_status_q &
                         ~pwdata[comparison_unit_pkg::EV_W-1:0]) | ev;
      end else begin
        irq_status_q <= irq_status_q | ev;
      end
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule : comparison_unit

// [src/comparison_unit_pkg.sv]
package comparison_unit_pkg;

  localparam int ADDR_W = 15;
  localparam int CHAR_W = 6;
  localparam int MAX_LEN = 16;
  localparam int LEN_W = 4;
  localparam int TGT_W = 17;
  localparam int AR_WORDS = 4;
  localparam int FIELD_W = MAX_LEN * CHAR_W;

  // register byte offsets
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] BASE_OFF = 8'h04;
  localparam logic [7:0] INDEX_OFF = 8'h08;
  localparam logic [7:0] EA_OFF = 8'h0c;
  localparam logic [7:0] AR0_OFF = 8'h10;
  localparam logic [7:0] AR1_OFF = 8'h14;
  localparam logic [7:0] AR2_OFF = 8'h18;
  localparam logic [7:0] AR3_OFF = 8'h1c;
  localparam logic [7:0] TETRAD_OFF = 8'h20;
  localparam logic [7:0] FLAGS_OFF = 8'h24;
  localparam logic [7:0] IND_TEST_OFF = 8'h28;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h2c;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h30;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_LEN_LSB = 4;
  localparam int CMD_IMM_LSB = 8;
  localparam int CMD_START_BIT = 31;

  // flags register fields
  localparam int FLAGS_LOW_BIT = 0;
  localparam int FLAGS_UNEQUAL_BIT = 1;
  localparam int FLAGS_EQUAL_BIT = 2;
  localparam int FLAGS_HIGH_BIT = 3;
  localparam int FLAGS_BUSY_BIT = 8;

  // indicator numbers as seen by a conditional jump
  localparam logic [5:0] IND_HIGH_NUM = 6'h21;
  localparam logic [5:0] IND_EQUAL_NUM = 6'h22;
  localparam logic [5:0] IND_UNEQUAL_NUM = 6'h23;
  localparam logic [5:0] IND_LOW_NUM = 6'h24;

  // interrupt events
  localparam int EV_DONE = 0;
  localparam int EV_SIGN_STOP = 1;
  localparam int EV_W = 2;

  // decimal operand coding
  localparam int SIGN_BIT = 4;
  localparam int DIGIT_W = 4;
  localparam logic [5:0] SENTINEL = 6'h3c;

  // decimal compare duration, in tenths of a time unit
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TIME_UNIT_PS = 1000000;
  localparam int DEC_BASE_X10 = 360;
  localparam int DEC_DIGIT_X10 = 135;
  localparam int DEC_BASE_CYCLES =
    DEC_BASE_X10 * (TIME_UNIT_PS / CLK_PERIOD_PS) / 10;
  localparam int DEC_DIGIT_CYCLES =
    DEC_DIGIT_X10 * (TIME_UNIT_PS / CLK_PERIOD_PS) / 10;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_BINARY,
    OP_CHAR,
    OP_DECIMAL,
    OP_WORD,
    OP_MASKED
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT
  } state_t;

  typedef enum logic [1:0] {
    CMP_LT,
    CMP_EQ,
    CMP_GT
  } cmp_t;

endpackage : comparison_unit_pkg

// [test/char_memory.sv]
module char_memory (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [comparison_unit_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_valid,
  output logic [comparison_unit_pkg::CHAR_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] mem [0:32767];
  int delay = 0;
  int waited;
  // data toggles outside the valid pulse so a late sample never passes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem_rdata <= 6'h2a;
      waited <= 0;
    end else if (mem_req && !mem_valid && waited >= delay) begin
      mem_valid <= 1'b1;
      mem_rdata <= mem[mem_addr];
      waited <= 0;
    end else begin
      mem_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      waited <= (mem_req && !mem_valid) ? waited + 1 : 0;
    end
  end
endmodule : char_memory

// [test/comparison_unit_chk.sv]
module comparison_unit_chk #(
  parameter int DEC_BASE_CYCLES = 8,
  parameter int DEC_DIGIT_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [comparison_unit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [comparison_unit_pkg::CHAR_W-1:0] mem_rdata,
  input wire logic high_flag,
  input wire logic equal_flag,
  input wire logic unequal_flag,
  input wire logic low_flag,
  input wire logic busy,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic [3:0] flags = {high_flag, equal_flag, unequal_flag, low_flag};

  a_flags_code: assert property (
    flags inside {4'h0, 4'h3, 4'h4, 4'ha}) else $error("bad flag pattern");
  a_flags_hold: assert property (
    flags != $past(flags) |-> $fell(busy)) else $error("flags moved");
  a_flags_done: assert property (
    $fell(busy) |-> flags inside {4'h3, 4'h4, 4'ha})
    else $error("no outcome at completion");
  a_fetch_busy: assert property (
    mem_req |-> busy) else $error("fetch while idle");
  a_req_hold: assert property (
    mem_req && !mem_valid |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped");
  a_addr_down: assert property (
    mem_req && mem_valid ##1 mem_req |-> mem_addr == $past(mem_addr) - 1'b1)
    else $error("fetch order broken");
  a_busy_bound: assert property (
    $rose(busy) |-> ##[1:400] !busy) else $error("compare never ends");
  a_ready_slot: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready slot wrong");
  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h0) else $error("read data outside slot");
endmodule : comparison_unit_chk

bind comparison_unit comparison_unit_chk #(
  .DEC_BASE_CYCLES(DEC_BASE_CYCLES),
  .DEC_DIGIT_CYCLES(DEC_DIGIT_CYCLES)
) u_comparison_unit_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .mem_req, .mem_addr, .mem_valid, .mem_rdata,
  .high_flag, .equal_flag, .unequal_flag, .low_flag, .busy, .irq
);

// [test/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DB = 8;
  localparam int DD = 2;
  localparam logic [14:0] EA = 15'h120;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic [14:0] mem_addr;
  logic [5:0] mem_rdata;
  logic pready, pslverr, mem_req, mem_valid, err_q, busy_d;
  logic high_flag, equal_flag, unequal_flag, low_flag, busy, irq;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int busy_len = 0;
  time t0 = 0;

  always #2.5 pclk = ~pclk;

  comparison_unit #(.DEC_BASE_CYCLES(DB), .DEC_DIGIT_CYCLES(DD))
    u_comparison_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_valid,
    .mem_rdata, .high_flag, .equal_flag, .unequal_flag, .low_flag, .busy,
    .irq);
  char_memory u_char_memory (.pclk, .presetn, .mem_req, .mem_addr,
    .mem_valid, .mem_rdata);

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // busy length in cycles, and a ceiling far above the expected run
  always @(posedge pclk) begin
    busy_d <= busy;
    if (busy === 1'b1 && busy_d !== 1'b1) t0 = $time;
    if (busy === 1'b0 && busy_d === 1'b1) busy_len = int'(($time - t0) / 5);
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one idle cycle after each transfer keeps every signal to one change
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic run(input logic [2:0] op, input int l, input logic [5:0] c,
                     input logic [3:0] exp);
    apb(1'b1, comparison_unit_pkg::CMD_OFF,
        {1'b1, 17'h0, c, 4'(l - 1), 1'b0, op});
    do apb(1'b0, comparison_unit_pkg::FLAGS_OFF, 32'h0);
    while (r[8] !== 1'b0);
    chk({28'h0, r[3:0]}, {28'h0, exp});
  endtask : run

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, comparison_unit_pkg::FLAGS_OFF, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    apb(1'b1, comparison_unit_pkg::BASE_OFF, 32'h100);
    apb(1'b1, comparison_unit_pkg::INDEX_OFF, 32'h20);
    u_char_memory.mem[EA] = 6'h1a;
    run(3'h1, 1, 6'h17, 4'h3);
    // the indexed address is only latched when a compare starts
    apb(1'b0, comparison_unit_pkg::EA_OFF, 32'h0);
    chk(r, 32'h120);
    run(3'h1, 1, 6'h1a, 4'h4);
    run(3'h1, 1, 6'h1b, 4'ha);
    u_char_memory.mem[EA] = 6'h3b;
    run(3'h4, 1, 6'h0b, 4'h4);
    u_char_memory.mem[EA] = 6'h0a;
    run(3'h4, 1, 6'h0b, 4'ha);
    u_char_memory.mem[EA] = 6'h0b;
    run(3'h4, 1, 6'h0b, 4'h4);
    apb(1'b0, comparison_unit_pkg::CMD_OFF, 32'h0);
    chk(r, 32'h0000_0b04);
    $display("character tests done");
    apb(1'b1, comparison_unit_pkg::AR0_OFF, 32'h3c);
    run(3'h0, 1, 6'h00, 4'ha);
    for (int i = 0; i < 16; i++) u_char_memory.mem[EA - i] = 6'h3f;
    for (int i = 0; i < 4; i++)
      apb(1'b1, comparison_unit_pkg::AR0_OFF + 8'(4 * i), 32'h00ff_ffff);
    u_char_memory.delay = 2;
    run(3'h0, 16, 6'h00, 4'h4);
    apb(1'b1, comparison_unit_pkg::AR3_OFF, 32'h00fb_ffff);
    run(3'h0, 16, 6'h00, 4'h3);
    apb(1'b0, comparison_unit_pkg::AR3_OFF, 32'h0);
    chk(r, 32'h00fb_ffff);
    u_char_memory.delay = 0;
    apb(1'b1, comparison_unit_pkg::AR0_OFF, 32'h0fff);
    run(3'h0, 2, 6'h00, 4'h4);
    $display("binary tests done");
    for (int i = 1; i < 4; i++) u_char_memory.mem[EA - i] = 6'h00;
    apb(1'b1, comparison_unit_pkg::TETRAD_OFF, 32'h40);
    run(3'h3, 1, 6'h00, 4'ha);
    apb(1'b1, comparison_unit_pkg::TETRAD_OFF, 32'h3f);
    run(3'h3, 1, 6'h00, 4'h4);
    $display("word tests done");
    apb(1'b1, comparison_unit_pkg::AR0_OFF, 32'h0003_c042);
    u_char_memory.mem[EA] = 6'h03;
    u_char_memory.mem[EA - 1] = 6'h01;
    apb(1'b1, comparison_unit_pkg::IRQ_STATUS_OFF, 32'h3);
    run(3'h2, 4, 6'h00, 4'h3);
    chk({31'h0, busy_len >= DB + 4 * DD && busy_len <= DB + 4 * DD + 4},
        32'h1);
    u_char_memory.mem[EA] = 6'h13;
    run(3'h2, 4, 6'h00, 4'ha);
    chk({31'h0, busy_len >= DB && busy_len <= DB + 4}, 32'h1);
    apb(1'b0, comparison_unit_pkg::IRQ_STATUS_OFF, 32'h0);
    chk(r, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, comparison_unit_pkg::IRQ_MASK_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, comparison_unit_pkg::IRQ_STATUS_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("decimal and interrupt tests done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, comparison_unit_pkg::IND_TEST_OFF,
          {18'h0, 6'h21 + 6'(i), 8'h00});
      for (int j = 0; j < 2; j++) begin
        apb(1'b0, comparison_unit_pkg::IND_TEST_OFF, 32'h0);
        chk({31'h0, r[0]}, {31'h0, !i[0]});
      end
    end
    chk({28'h0, high_flag, equal_flag, unequal_flag, low_flag},
        32'ha);
    $display("indicator tests done");
    print_verdict();
  end
endmodule : testbench
